// ==== common/mdc_if.sv ====
/*
 * Shared system bus between the host end and the decoder end.
 * Assumes both ends run on the same clock; the bench joins the modports.
 */
`timescale 1ns/1ps
interface mdc_if;
	logic [15:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] ireg;
	logic dsp_owns;
	modport dev (
		input addr,
		input wdata,
		input wr,
		input rd,
		input ireg,
		output dsp_owns
	);
	modport host (
		output addr,
		output wdata,
		output wr,
		output rd,
		output ireg,
		input dsp_owns
	);
endinterface

// ==== common/mdc_pkg.sv ====
/*
 * Constants shared by the memory decoder / control register (device end) and the
 * bus owner side model end (host end).
 * Assumes a single 125 MHz system clock and synchronous active-low reset.
 */
package mdc_pkg;
	// ************************************************
	// address map
	// ************************************************
	localparam logic [15:0] BLOCK_BASE = 16'h4000;
	localparam logic [15:0] HOST_COPROC = 16'h5000;
	localparam logic [15:0] HOST_SERIAL = 16'h5400;
	localparam logic [15:0] HOST_REG1 = 16'h5800;
	localparam logic [15:0] HOST_BUS_RETURN_REGISTER = 16'h5C00;
	localparam logic [15:0] SHARED_BASE = 16'h6000;
	localparam logic [15:0] DSP_REG1 = 16'h6800;
	localparam logic [15:0] DSP_BUS_RETURN_REGISTER = 16'h6C00;
	localparam logic [15:0] DSP_COPROC = 16'h7000;
	localparam logic [15:0] DSP_SERIAL = 16'h7400;
	localparam logic [15:0] DSP_INTERNAL = 16'h7800;
	// ************************************************
	// i register and control register fields
	// ************************************************
	localparam int IREG_ROM_LSB = 0;
	localparam int IREG_SRAM_BANK = 4;
	localparam int CTL_SAVE_SRAM = 0;
	localparam int CTL_DIGOUT = 1;
	localparam int CTL_PASS = 2;
	localparam int CTL_SER_RST = 3;
	localparam int CTL_PERMIT = 4;
	localparam int CTL_EXT_RATE = 5;
	localparam int CTL_PLL_N = 6;
	localparam int CTL_SRC_DIG = 7;
	localparam logic [7:0] CTL_RESET = 8'h00;
	// ************************************************
	// timing
	// ************************************************
	localparam int CLK_MHZ = 125;
	localparam int SER_RST_NS = 1000;
	localparam int SER_RST_CYC = (SER_RST_NS * CLK_MHZ + 999) / 1000;
	// ************************************************
	// decode targets
	// ************************************************
	typedef enum logic [3:0] {
		MDC_NONE,
		MDC_COMMON_ROM,
		MDC_BANK_ROM,
		MDC_SRAM,
		MDC_DSP_BUF,
		MDC_COPROC,
		MDC_SERIAL,
		MDC_REG1,
		MDC_BUS_RETURN_REGISTER,
		MDC_DSP_INT
	} mdc_target_e;
endpackage

// ==== logic/mdc_decoder.sv ====
/*
 * Device end: address decode, rom/sram bank switching, control register 1
 * and bus ownership between host and dsp.
 * Assumes bus signals synchronous to clk_sys_in; the host end keeps its own duties.
 */
`timescale 1ns/1ps
module mdc_decoder (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	mdc_if.dev bus,
	input wire logic coproc_bus_request_in,
	input wire logic phase_raw_in,
	input wire logic digital_out_raw_in,
	output logic [3:0] target_out,
	output logic [15:0] eff_addr_out,
	output logic [14:0] sram_addr_out,
	output logic sram_lo_we_out,
	output logic sram_hi_en_out,
	output logic [2:0] rom_bank_lines_out,
	output logic digital_out_gate_out,
	output logic pass_channel_status_out,
	output logic serial_reset_out,
	output logic external_rate_select_out,
	output logic pll_phase_drive_out,
	output logic source_digital_out
);
	logic [7:0] ctl_q;
	logic dsp_q;
	logic req_d1_q;
	logic [15:0] a;
	logic sram_bank_line;
	mdc_pkg::mdc_target_e tgt;

	// ************************************************
	// effective address and bank line
	// ************************************************
	always_comb begin
		a = bus.addr;
		// the dsp leaves a15/a14 undriven, so the decode must use their pulled levels
		// force a15 a14
		if (dsp_q) begin
			a[15] = 1'b0;
			a[14] = 1'b1;
		end
	end
	assign sram_bank_line = bus.ireg[mdc_pkg::IREG_SRAM_BANK] & ~dsp_q;

	// ************************************************
	// map helpers
	// ************************************************
	// peripherals sit on 1k pages, so only a15..a10 take part in the match
	function automatic logic same_page(input logic [15:0] ad, input logic [15:0] base);
		return ad[15:10] == base[15:10];
	endfunction

	// a write strobe aimed at one decode target
	function automatic logic write_hits(input logic wr, input mdc_pkg::mdc_target_e t,
		input mdc_pkg::mdc_target_e want);
		return wr && (t == want);
	endfunction

	function automatic mdc_pkg::mdc_target_e host_map(input logic [15:0] ad, input logic bank);
		mdc_pkg::mdc_target_e t;
		t = mdc_pkg::MDC_SRAM;
		if (!bank) begin
			if (same_page(ad, mdc_pkg::HOST_COPROC))
				t = mdc_pkg::MDC_COPROC;
			else if (same_page(ad, mdc_pkg::HOST_SERIAL))
				t = mdc_pkg::MDC_SERIAL;
			else if (same_page(ad, mdc_pkg::HOST_REG1))
				t = mdc_pkg::MDC_REG1;
			else if (same_page(ad, mdc_pkg::HOST_BUS_RETURN_REGISTER))
				t = mdc_pkg::MDC_BUS_RETURN_REGISTER;
		end
		return t;
	endfunction

	function automatic mdc_pkg::mdc_target_e dsp_map(input logic [15:0] ad);
		mdc_pkg::mdc_target_e t;
		t = mdc_pkg::MDC_SRAM;
		if (ad < mdc_pkg::SHARED_BASE)
			t = mdc_pkg::MDC_DSP_BUF;
		else if (ad >= mdc_pkg::DSP_INTERNAL)
			t = mdc_pkg::MDC_DSP_INT;
		else if (same_page(ad, mdc_pkg::DSP_REG1))
			t = mdc_pkg::MDC_REG1;
		else if (same_page(ad, mdc_pkg::DSP_BUS_RETURN_REGISTER))
			t = mdc_pkg::MDC_BUS_RETURN_REGISTER;
		else if (same_page(ad, mdc_pkg::DSP_COPROC))
			t = mdc_pkg::MDC_COPROC;
		else if (same_page(ad, mdc_pkg::DSP_SERIAL))
			t = mdc_pkg::MDC_SERIAL;
		return t;
	endfunction

	// ************************************************
	// decode
	// ************************************************
	always_comb begin
		if (a[15])
			tgt = mdc_pkg::MDC_BANK_ROM;
		else if (!a[14])
			tgt = mdc_pkg::MDC_COMMON_ROM;
		else if (dsp_q)
			tgt = dsp_map(a);
		else
			tgt = host_map(a, sram_bank_line);
	end
	assign target_out = tgt;
	assign eff_addr_out = a;
	assign rom_bank_lines_out = bus.ireg[mdc_pkg::IREG_ROM_LSB +: 3];
	// shared 2k aliases
	// sram a13..a0 pass through, so with the i register bank bit clear 0x6000 lands at the same cell for both owners
	assign sram_addr_out = {sram_bank_line, a[13:0]};
	assign sram_hi_en_out = (tgt == mdc_pkg::MDC_DSP_BUF);
	// the high byte belongs to the dsp alone, so only the low byte is guarded
	// write protect
	assign sram_lo_we_out = bus.wr && (tgt == mdc_pkg::MDC_SRAM || tgt == mdc_pkg::MDC_DSP_BUF)
		&& !(dsp_q && ctl_q[mdc_pkg::CTL_SAVE_SRAM]);

	// ************************************************
	// control register
	// ************************************************
	// there is no read path: a read of register one returns nothing
	// write-only register
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in)
			ctl_q <= mdc_pkg::CTL_RESET;
		else if (write_hits(bus.wr, tgt, mdc_pkg::MDC_REG1))
			ctl_q <= bus.wdata;
	end

	// ************************************************
	// bus ownership
	// ************************************************
	// request edge
	// the edge is taken against the previous cycle, so a request left high
	// after the bus comes back cannot grab it a second time
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in)
			req_d1_q <= 1'b0;
		else
			req_d1_q <= coproc_bus_request_in;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			dsp_q <= 1'b0;
		end else begin
			if (dsp_q && write_hits(bus.wr, tgt, mdc_pkg::MDC_BUS_RETURN_REGISTER))
				dsp_q <= 1'b0;
			else if (!dsp_q && coproc_bus_request_in && !req_d1_q && ctl_q[mdc_pkg::CTL_PERMIT])
				dsp_q <= 1'b1;
			// clearing the permit drops ownership on the clock after ctl_q loses it
			else if (!ctl_q[mdc_pkg::CTL_PERMIT])
				dsp_q <= 1'b0;
		end
	end
	assign bus.dsp_owns = dsp_q;

	// ************************************************
	// control outputs
	// ************************************************
	// raw lines are gated, not registered, so the gates add no latency
	// digital out gate
	assign digital_out_gate_out = digital_out_raw_in & ctl_q[mdc_pkg::CTL_DIGOUT];
	assign pass_channel_status_out = ctl_q[mdc_pkg::CTL_PASS];
	assign serial_reset_out = ctl_q[mdc_pkg::CTL_SER_RST];
	assign external_rate_select_out = ctl_q[mdc_pkg::CTL_EXT_RATE];
	assign pll_phase_drive_out = phase_raw_in & ctl_q[mdc_pkg::CTL_PLL_N];
	assign source_digital_out = ctl_q[mdc_pkg::CTL_SRC_DIG];
endmodule

// ==== logic/mdc_host.sv ====
/*
 * Host end: runs single bus writes/reads from a user command port, keeps the
 * i register, and after reset holds the serial port in reset for 1 us.
 * Assumes the decoder end on the same clock.
 */
`timescale 1ns/1ps
module mdc_host (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	mdc_if.host bus,
	input wire logic cmd_valid_in,
	input wire logic cmd_write_in,
	input wire logic [15:0] cmd_addr_in,
	input wire logic [7:0] cmd_data_in,
	input wire logic ireg_load_in,
	input wire logic [7:0] ireg_data_in,
	output logic cmd_ready_out,
	output logic irq_mask_out,
	output logic init_done_out
);
	typedef enum logic [1:0] {MDC_INIT, MDC_HOLD, MDC_IDLE, MDC_ACC} mdc_state_e;
	mdc_state_e st_q;
	logic [7:0] cnt_q;
	logic [7:0] ireg_q;
	logic [15:0] addr_q;
	logic [7:0] data_q;
	logic wr_q;
	logic rd_q;

	// ************************************************
	// i register
	// ************************************************
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in)
			ireg_q <= 8'h00;
		else if (ireg_load_in)
			ireg_q <= ireg_data_in;
	end
	assign bus.ireg = ireg_q;
	assign irq_mask_out = ireg_q[mdc_pkg::IREG_SRAM_BANK];

	// ************************************************
	// access sequencer
	// ************************************************
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			st_q <= MDC_INIT;
			cnt_q <= 8'h00;
			addr_q <= 16'h0000;
			data_q <= 8'h00;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
		end else begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			case (st_q)
				MDC_INIT: begin
					addr_q <= mdc_pkg::HOST_REG1;
					data_q <= 8'h00 | (8'h01 << mdc_pkg::CTL_SER_RST);
					wr_q <= 1'b1;
					cnt_q <= 8'h00;
					st_q <= MDC_HOLD;
				end
				MDC_HOLD: begin
					cnt_q <= cnt_q + 8'h01;
					if (cnt_q == 8'(mdc_pkg::SER_RST_CYC)) begin
						addr_q <= mdc_pkg::HOST_REG1;
						data_q <= mdc_pkg::CTL_RESET;
						wr_q <= 1'b1;
						st_q <= MDC_IDLE;
					end
				end
				MDC_IDLE: begin
					// the host stalls while the dsp owns the bus
					if (cmd_valid_in && !bus.dsp_owns) begin
						addr_q <= cmd_addr_in;
						data_q <= cmd_data_in;
						wr_q <= cmd_write_in;
						rd_q <= !cmd_write_in;
						st_q <= MDC_ACC;
					end
				end
				MDC_ACC: st_q <= MDC_IDLE;
				default: st_q <= MDC_INIT;
			endcase
		end
	end
	assign bus.addr = addr_q;
	assign bus.wdata = data_q;
	assign bus.wr = wr_q;
	assign bus.rd = rd_q;
	assign cmd_ready_out = (st_q == MDC_IDLE) && !bus.dsp_owns;
	assign init_done_out = (st_q == MDC_IDLE) || (st_q == MDC_ACC);
endmodule

// ==== testbench/mdc_bus_asserts.sv ====
/*
 * checker for the shared bus between host end and decoder end.
 * assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module mdc_bus_asserts (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic coproc_bus_request_in,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic dsp_owns
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);
	// ************************
	// helpers
	// ************************
	logic [7:0] gap_q;
	logic [1:0] wcnt_q;
	// saturates so long idle spells cannot wrap
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in || wr) begin
			gap_q <= 8'h00;
		end else if (gap_q != 8'hff) begin
			gap_q <= gap_q + 8'h01;
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			wcnt_q <= 2'h0;
		end else if (wr && wcnt_q != 2'h2) begin
			wcnt_q <= wcnt_q + 2'h1;
		end
	end
	sequence init_wr;
		wr && addr == 16'h5800 && wdata == 8'h08;
	endsequence
	// ************************
	// properties
	// ************************
	chk_init_order: assert property ($rose(rstn_in) |-> ##[0:3] init_wr)
		else $error("serial port not put in reset after reset");
	chk_hold_time: assert property (wr && wcnt_q == 2'h1 |-> gap_q >= 8'(mdc_pkg::SER_RST_CYC))
		else $error("serial port reset released too early");
	chk_wr_pulse: assert property (wr |=> !wr)
		else $error("write strobe longer than one cycle");
	chk_rd_pulse: assert property (rd |=> !rd)
		else $error("read strobe longer than one cycle");
	chk_one_strobe: assert property (!(wr && rd))
		else $error("read and write together");
	chk_grant_cause: assert property ($rose(dsp_owns) |->
		$past(coproc_bus_request_in) && !$past(coproc_bus_request_in, 2))
		else $error("ownership without request edge");
	chk_owner_quiet: assert property (dsp_owns && $past(dsp_owns) |-> !wr && !rd)
		else $error("host strobes while dsp owns bus");
	chk_owner_holds: assert property (dsp_owns && !wr |=> dsp_owns)
		else $error("ownership lost without a write");
endmodule

// ==== testbench/memory_decode_and_control_register_tb.sv ====
/*
 * bench: host and decoder ends joined; a second decoder end is driven as the dsp.
 * assumes package and interface compiled first.
 */
`timescale 1ns/1ps
module memory_decode_and_control_register_tb;
	// ************************
	// wiring
	// ************************
	logic clk_sys_in = 1'b0;
	logic rstn_in = 1'b0;
	logic cv = 1'b0, cw = 1'b0, il = 1'b0, rq = 1'b0, rq2 = 1'b0, ph = 1'b1, dg = 1'b1, probe = 1'b0;
	logic [15:0] ca = 16'h0000;
	logic [7:0] cd = 8'h00, id = 8'h00, r;
	logic rdy, init, irm, lw, he, sr, dgo, pcs, ext, pll, src;
	logic [3:0] t1, t2;
	logic [2:0] rb;
	logic [14:0] s1, s2;
	logic [15:0] e2;
	int bad_count = 0, cmp_count = 0, cyc = 0;
	logic [35:0] note_q[$];
	logic [15:0] ha[13] = '{16'h0000, 16'h8000, 16'hC123, 16'h4000, 16'h5000, 16'h5400, 16'h5800,
		16'h5C00, 16'h6000, 16'h7FFF, 16'h5000, 16'h5C00, 16'h4000};
	logic [7:0] hi[13] = '{8'h05, 8'h05, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h10, 8'h10, 8'h10};
	mdc_pkg::mdc_target_e ht[13] = '{mdc_pkg::MDC_COMMON_ROM, mdc_pkg::MDC_BANK_ROM, mdc_pkg::MDC_BANK_ROM,
		mdc_pkg::MDC_SRAM, mdc_pkg::MDC_COPROC, mdc_pkg::MDC_SERIAL, mdc_pkg::MDC_REG1, mdc_pkg::MDC_BUS_RETURN_REGISTER,
		mdc_pkg::MDC_SRAM, mdc_pkg::MDC_SRAM, mdc_pkg::MDC_SRAM, mdc_pkg::MDC_SRAM, mdc_pkg::MDC_SRAM};
	logic [15:0] da[9] = '{16'h0000, 16'h1C00, 16'h2000, 16'h2800, 16'h2C00, 16'h3000, 16'h3400,
		16'h3800, 16'h8000};
	mdc_pkg::mdc_target_e dt[9] = '{mdc_pkg::MDC_DSP_BUF, mdc_pkg::MDC_DSP_BUF, mdc_pkg::MDC_SRAM,
		mdc_pkg::MDC_REG1, mdc_pkg::MDC_BUS_RETURN_REGISTER, mdc_pkg::MDC_COPROC, mdc_pkg::MDC_SERIAL,
		mdc_pkg::MDC_DSP_INT, mdc_pkg::MDC_DSP_BUF};
	mdc_if b1();
	mdc_if b2();
	initial forever #4 clk_sys_in = ~clk_sys_in;
	mdc_host u_mdc_host (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .bus(b1), .cmd_valid_in(cv),
		.cmd_write_in(cw), .cmd_addr_in(ca), .cmd_data_in(cd), .ireg_load_in(il), .ireg_data_in(id),
		.cmd_ready_out(rdy), .irq_mask_out(irm), .init_done_out(init));
	mdc_decoder u_mdc_decoder (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .bus(b1), .coproc_bus_request_in(rq),
		.phase_raw_in(ph), .digital_out_raw_in(dg), .target_out(t1), .eff_addr_out(), .sram_addr_out(s1),
		.sram_lo_we_out(), .sram_hi_en_out(), .rom_bank_lines_out(rb), .digital_out_gate_out(dgo),
		.pass_channel_status_out(pcs), .serial_reset_out(sr), .external_rate_select_out(ext),
		.pll_phase_drive_out(pll), .source_digital_out(src));
	// dsp side: its own decoder so the bench may drive the bus directly
	mdc_decoder u_mdc_decoder_dsp (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .bus(b2),
		.coproc_bus_request_in(rq2), .phase_raw_in(ph), .digital_out_raw_in(dg), .target_out(t2),
		.eff_addr_out(e2), .sram_addr_out(s2), .sram_lo_we_out(lw), .sram_hi_en_out(he),
		.rom_bank_lines_out(), .digital_out_gate_out(), .pass_channel_status_out(), .serial_reset_out(),
		.external_rate_select_out(), .pll_phase_drive_out(), .source_digital_out());
	mdc_bus_asserts u_mdc_bus_asserts (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .coproc_bus_request_in(rq),
		.addr(b1.addr), .wdata(b1.wdata), .wr(b1.wr), .rd(b1.rd), .dsp_owns(b1.dsp_owns));
	// ************************
	// tasks
	// ************************
	task automatic check(string n, logic [31:0] s, logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic note(logic [3:0] k, logic [31:0] e);
		note_q.push_back({k, e});
		probe = 1'b1;
		@(negedge clk_sys_in);
		probe = 1'b0;
		@(negedge clk_sys_in);
	endtask
	task automatic hcmd(logic w, logic [15:0] a, logic [7:0] d);
		for (int i = 0; i < 400 && rdy !== 1'b1; i++) @(negedge clk_sys_in);
		cv = 1'b1;
		cw = w;
		ca = a;
		cd = d;
		@(negedge clk_sys_in);
		cv = 1'b0;
		@(negedge clk_sys_in);
	endtask
	task automatic dacc(logic [15:0] a, logic [7:0] d);
		b2.addr = a;
		b2.wdata = d;
		b2.wr = 1'b1;
		@(negedge clk_sys_in);
		b2.wr = 1'b0;
		@(negedge clk_sys_in);
	endtask
	task automatic released();
		rstn_in = 1'b1;
		repeat (3) @(negedge clk_sys_in);
		note(4'h0, 32'h0000_0004);
		note(4'h7, 32'h0000_0000);
		for (int i = 0; i < 400 && init !== 1'b1; i++) @(negedge clk_sys_in);
		note(4'h7, 32'h0000_0001);
	endtask
	// ************************
	// watcher and sequence
	// ************************
	always @(posedge clk_sys_in) begin
		logic [35:0] n;
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			complete_run();
		end else if (probe && note_q.size() > 0) begin
			n = note_q.pop_front();
			case (n[35:32])
				4'h0: check("ctl", 32'({src, pll, ext, sr, pcs, dgo}), n[31:0]);
				4'h1: check("host map", 32'({t1, rb, irm}), n[31:0]);
				4'h2: check("host sram", 32'(s1), n[31:0]);
				4'h3: check("dsp map", 32'({t2, e2}), n[31:0]);
				4'h4: check("dsp sram", 32'({s2, lw, he}), n[31:0]);
				4'h5: check("dsp owner", 32'(b2.dsp_owns), n[31:0]);
				4'h7: check("host init", 32'(init), n[31:0]);
				default: check("host ready", 32'({rdy, b1.dsp_owns}), n[31:0]);
			endcase
		end
	end
	initial begin
		void'($urandom(32'h0000_5f70));
		b2.addr = 16'h0000;
		b2.wdata = 8'h00;
		b2.wr = 1'b0;
		b2.rd = 1'b0;
		b2.ireg = 8'h00;
		repeat (2) @(negedge clk_sys_in);
		released();
		repeat (8) begin
			r = 8'($urandom);
			ph = 1'($urandom);
			dg = 1'($urandom);
			hcmd(1'b1, 16'h5800, r);
			note(4'h0, 32'({r[7], r[6] & ph, r[5], r[3], r[2], r[1] & dg}));
		end
		for (int i = 0; i < 13; i++) begin
			il = 1'b1;
			id = hi[i];
			@(negedge clk_sys_in);
			il = 1'b0;
			hcmd(1'b0, ha[i], 8'h00);
			note(4'h1, 32'({ht[i], hi[i][2:0], hi[i][4]}));
			if (ht[i] == mdc_pkg::MDC_SRAM) note(4'h2, 32'({hi[i][4], ha[i][13:0]}));
		end
		dacc(16'h5800, 8'h11);
		// bank line high on purpose: ownership must still force bank zero
		b2.ireg = 8'h10;
		rq2 = 1'b1;
		@(negedge clk_sys_in);
		note(4'h5, 32'h0000_0001);
		for (int i = 0; i < 9; i++) begin
			b2.addr = da[i];
			note(4'h3, 32'({dt[i], 2'b01, da[i][13:0]}));
		end
		b2.wr = 1'b1;
		b2.addr = 16'h0010;
		note(4'h4, 32'({15'h0010, 1'b0, 1'b1}));
		b2.addr = 16'h2010;
		note(4'h4, 32'({15'h2010, 1'b0, 1'b0}));
		dacc(16'h2800, 8'h10);
		b2.wr = 1'b1;
		b2.addr = 16'h0010;
		note(4'h4, 32'({15'h0010, 1'b1, 1'b1}));
		dacc(16'h2C00, 8'h00);
		@(negedge clk_sys_in);
		note(4'h5, 32'h0000_0000);
		// bank line low again so the host-side write reaches register one
		b2.ireg = 8'h00;
		dacc(16'h5800, 8'h00);
		rq2 = 1'b0;
		@(negedge clk_sys_in);
		rq2 = 1'b1;
		repeat (2) @(negedge clk_sys_in);
		note(4'h5, 32'h0000_0000);
		il = 1'b1;
		id = 8'h00;
		@(negedge clk_sys_in);
		il = 1'b0;
		hcmd(1'b1, 16'h5800, 8'h10);
		rq = 1'b1;
		repeat (2) @(negedge clk_sys_in);
		note(4'h6, 32'h0000_0001);
		rstn_in = 1'b0;
		rq = 1'b0;
		repeat (2) @(negedge clk_sys_in);
		note(4'h0, 32'h0000_0000);
		released();
		complete_run();
	end
endmodule
